// [tcwu_ch_if.sv]
// Purpose: Carrier between the counter core and one compare output channel.
// Assumes: Single clock domain.
// Notes: Core drives events, channel returns its output state.
`default_nettype none
interface tcwu_ch_if;
	logic match;
	logic bottom_evt;
	logic pwm_mode;
	logic force_evt;
	logic [1:0] action;
	logic out_state;
	modport core (output match, output bottom_evt, output pwm_mode, output force_evt,
		output action, input out_state);
	modport chan (input match, input bottom_evt, input pwm_mode, input force_evt,
		input action, output out_state);
endinterface : tcwu_ch_if
`default_nettype wire

// [tcwu_output_unit.sv]
// Purpose: Compare output state and its update on match, bottom and force.
// Assumes: Match and bottom events arrive already qualified by the timer clock enable; force strobes arrive unqualified.
// Notes: State survives mode changes; only events move it.
`default_nettype none
module tcwu_output_unit (
	input wire logic clk_i,
	input wire logic rst_n_i,
	tcwu_ch_if.chan ch
);
	logic out_reg;
	logic out_next;
	logic nonpwm_hit;
	logic fast_match;
	logic fast_bottom;

	assign nonpwm_hit = !ch.pwm_mode && (ch.match || ch.force_evt);
	assign fast_match = ch.pwm_mode && ch.match;
	assign fast_bottom = ch.pwm_mode && ch.bottom_evt;

	// Action select is read live, never buffered
	always_comb begin
		out_next = out_reg;
		if (nonpwm_hit) begin
			unique case (ch.action)
				tcwu_pkg::ACT_NONE: out_next = out_reg;
				tcwu_pkg::ACT_TOGGLE: out_next = !out_reg;
				tcwu_pkg::ACT_CLEAR: out_next = 1'b0;
				tcwu_pkg::ACT_SET: out_next = 1'b1;
			endcase
		end else if (fast_match) begin
			unique case (ch.action)
				tcwu_pkg::ACT_NONE: out_next = out_reg;
				tcwu_pkg::ACT_TOGGLE: out_next = !out_reg;
				tcwu_pkg::ACT_CLEAR: out_next = 1'b0;
				tcwu_pkg::ACT_SET: out_next = 1'b1;
			endcase
		end else if (fast_bottom) begin
			unique case (ch.action)
				tcwu_pkg::ACT_CLEAR: out_next = 1'b1;
				tcwu_pkg::ACT_SET: out_next = 1'b0;
				default: out_next = out_reg;
			endcase
		end
	end

	// Match wins over bottom so a compare equal to top takes the bottom action only on the first tick after a counter write, when the match is blocked
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_reg <= 1'b0;
		end else begin
			out_reg <= out_next;
		end
	end

	assign ch.out_state = out_reg;
endmodule : tcwu_output_unit
`default_nettype wire

// [tcwu_pin_model.sv]
// Purpose: Pad model for one compare output pin.
// Assumes: No pull on the pad.
// Notes: Undriven pad flips each cycle so a stale level never passes.
`default_nettype none
module tcwu_pin_model (
	input wire logic clk_i,
	input wire logic drv_i,
	input wire logic oe_i,
	output logic level_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic float_reg = 1'h0;
	always @(posedge clk_i) float_reg <= ~level_o;
	assign level_o = oe_i ? drv_i : float_reg;
endmodule : tcwu_pin_model
`default_nettype wire

// [tcwu_pkg.sv]
// Purpose: Shared constants and types for the timer compare waveform unit.
// Assumes: 8-bit counter, two compare channels A and B.
// Notes: Mode codes follow the three-bit waveform mode select.
`default_nettype none
package tcwu_pkg;
	localparam int CNT_W = 8;
	localparam logic [7:0] BOTTOM_VAL = 8'h00;
	localparam logic [7:0] MAX_VAL = 8'hFF;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [7:0] OCR_RST = 8'h00;
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
	localparam int N_CH = 2;

	typedef enum logic [2:0] {
		TCWU_MODE_NORMAL = 3'h0,
		TCWU_MODE_PC_FF = 3'h1,
		TCWU_MODE_CLEAR_ON_MATCH = 3'h2,
		TCWU_MODE_FAST_FF = 3'h3,
		TCWU_MODE_RSV4 = 3'h4,
		TCWU_MODE_PC_OCR = 3'h5,
		TCWU_MODE_RSV6 = 3'h6,
		TCWU_MODE_FAST_OCR = 3'h7
	} tcwu_mode_e;
endpackage : tcwu_pkg
`default_nettype wire

// [tcwu_timer.sv]
// Purpose: 8-bit timer counter with Normal, clear-on-match and fast PWM modes.
// Assumes: tick_i is a one-cycle timer clock enable from a prescaler.
// Notes: Phase correct modes are not built; their codes behave as Normal.
// Notes: In fast PWM a compare write waits in the buffer until the tick at top.
`default_nettype none
module tcwu_timer (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic [2:0] waveform_mode_select_i,
	input wire logic [1:0] output_action_select_a_i,
	input wire logic [1:0] output_action_select_b_i,
	input wire logic force_compare_strobe_a_i,
	input wire logic force_compare_strobe_b_i,
	input wire logic counter_write_i,
	input wire logic [7:0] counter_wdata_i,
	input wire logic compare_value_a_write_i,
	input wire logic compare_value_b_write_i,
	input wire logic [7:0] compare_wdata_i,
	input wire logic overflow_flag_clear_i,
	input wire logic compare_flag_a_clear_i,
	input wire logic compare_flag_b_clear_i,
	input wire logic port_data_a_i,
	input wire logic port_data_b_i,
	input wire logic pin_direction_bit_a_i,
	input wire logic pin_direction_bit_b_i,
	output logic [7:0] counter_value_o,
	output logic [7:0] compare_value_a_o,
	output logic [7:0] compare_value_b_o,
	output logic overflow_flag_o,
	output logic compare_flag_a_o,
	output logic compare_flag_b_o,
	output logic compare_output_a_o,
	output logic compare_output_b_o,
	output logic pin_a_o,
	output logic pin_a_oe_o,
	output logic pin_b_o,
	output logic pin_b_oe_o
);
	// ==========================================================
	// Declarations
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic [7:0] ocr_a_reg;
	logic [7:0] ocr_b_reg;
	logic [7:0] buf_a_reg;
	logic [7:0] buf_b_reg;
	logic block_reg;
	logic tov_reg;
	logic ocf_a_reg;
	logic ocf_b_reg;
	logic pwm_mode;
	logic ctc_mode;
	logic top_is_ocr;
	logic [7:0] top_val;
	logic at_top;
	logic at_max;
	logic clear_now;
	logic match_a;
	logic match_b;
	logic tov_set;
	logic bottom_evt;
	logic tov_on_wrap;
	logic tov_on_top;
	logic tov_next;
	logic ocf_a_next;
	logic ocf_b_next;
	logic [7:0] ocr_a_next;
	logic [7:0] ocr_b_next;
	tcwu_pkg::tcwu_mode_e mode;

	tcwu_ch_if ch_a();
	tcwu_ch_if ch_b();

	function automatic logic is_match(input logic [7:0] cnt, input logic [7:0] ocr,
		input logic tick, input logic blocked);
		is_match = tick && !blocked && (cnt == ocr);
	endfunction : is_match

	// Hardware set wins over a software clear in the same cycle
	function automatic logic flag_update(input logic set, input logic cur, input logic clr);
		flag_update = set || (cur && !clr);
	endfunction : flag_update

	// Direct write outside PWM; PWM loads the compare from the buffer only at top
	function automatic logic [7:0] ocr_update(input logic [7:0] ocr, input logic [7:0] shadow,
		input logic wr, input logic [7:0] wdata, input logic pwm, input logic load);
		if (!pwm) begin
			ocr_update = wr ? wdata : ocr;
		end else begin
			ocr_update = load ? shadow : ocr;
		end
	endfunction : ocr_update

	function automatic logic pin_mux(input logic [1:0] action, input logic state,
		input logic port_data);
		pin_mux = (action != tcwu_pkg::ACT_NONE) ? state : port_data;
	endfunction : pin_mux

	// Software sees the buffer while buffering is active
	function automatic logic [7:0] sw_view(input logic pwm, input logic [7:0] shadow,
		input logic [7:0] ocr);
		sw_view = pwm ? shadow : ocr;
	endfunction : sw_view

	// ==========================================================
	// Mode decode
	assign mode = tcwu_pkg::tcwu_mode_e'(waveform_mode_select_i);
	assign pwm_mode = (mode == tcwu_pkg::TCWU_MODE_FAST_FF)
		|| (mode == tcwu_pkg::TCWU_MODE_FAST_OCR);
	assign ctc_mode = (mode == tcwu_pkg::TCWU_MODE_CLEAR_ON_MATCH);
	assign top_is_ocr = (mode == tcwu_pkg::TCWU_MODE_FAST_OCR);
	assign top_val = top_is_ocr ? ocr_a_reg : tcwu_pkg::MAX_VAL;
	assign at_top = (cnt_reg == top_val);
	assign at_max = (cnt_reg == tcwu_pkg::MAX_VAL);

	// ==========================================================
	// Matches, blocked for one tick after a counter write
	assign match_a = is_match(cnt_reg, ocr_a_reg, tick_i, block_reg);
	assign match_b = is_match(cnt_reg, ocr_b_reg, tick_i, block_reg);

	// Unbuffered compare A in clear-on-match: a skipped value wraps round
	assign clear_now = tick_i && ((ctc_mode && match_a) || (pwm_mode && at_top));

	assign bottom_evt = tick_i && pwm_mode && at_top;

	// Overflow: roll from max in non-PWM, reaching top in fast PWM
	assign tov_on_wrap = !pwm_mode && at_max;
	assign tov_on_top = pwm_mode && at_top;
	assign tov_set = tick_i && (tov_on_wrap || tov_on_top);

	// ==========================================================
	// Counter next value
	always_comb begin
		cnt_next = cnt_reg;
		if (counter_write_i) begin
			cnt_next = counter_wdata_i;
		end else if (clear_now) begin
			cnt_next = tcwu_pkg::BOTTOM_VAL;
		end else if (tick_i) begin
			cnt_next = cnt_reg + 8'h01;
		end
	end

	// ==========================================================
	// Counter
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= tcwu_pkg::CNT_RST;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// ==========================================================
	// Match blocking after a counter write
	// Block holds until the next tick has passed, even when stopped
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			block_reg <= 1'b0;
		end else if (counter_write_i) begin
			block_reg <= 1'b1;
		end else if (tick_i) begin
			block_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Compare registers: buffered in PWM, direct otherwise
	assign ocr_a_next = ocr_update(ocr_a_reg, buf_a_reg, compare_value_a_write_i,
		compare_wdata_i, pwm_mode, bottom_evt);
	assign ocr_b_next = ocr_update(ocr_b_reg, buf_b_reg, compare_value_b_write_i,
		compare_wdata_i, pwm_mode, bottom_evt);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			buf_a_reg <= tcwu_pkg::OCR_RST;
			ocr_a_reg <= tcwu_pkg::OCR_RST;
		end else begin
			if (compare_value_a_write_i) begin
				buf_a_reg <= compare_wdata_i;
			end
			ocr_a_reg <= ocr_a_next;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			buf_b_reg <= tcwu_pkg::OCR_RST;
			ocr_b_reg <= tcwu_pkg::OCR_RST;
		end else begin
			if (compare_value_b_write_i) begin
				buf_b_reg <= compare_wdata_i;
			end
			ocr_b_reg <= ocr_b_next;
		end
	end

	// ==========================================================
	// Flags: hardware set wins over software clear
	assign tov_next = flag_update(tov_set, tov_reg, overflow_flag_clear_i);
	// Force strobes never reach the flags
	assign ocf_a_next = flag_update(match_a, ocf_a_reg, compare_flag_a_clear_i);
	assign ocf_b_next = flag_update(match_b, ocf_b_reg, compare_flag_b_clear_i);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tov_reg <= 1'b0;
		end else begin
			tov_reg <= tov_next;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ocf_a_reg <= 1'b0;
		end else begin
			ocf_a_reg <= ocf_a_next;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ocf_b_reg <= 1'b0;
		end else begin
			ocf_b_reg <= ocf_b_next;
		end
	end

	// ==========================================================
	// Output channels
	assign ch_a.match = match_a;
	assign ch_a.bottom_evt = bottom_evt;
	assign ch_a.pwm_mode = pwm_mode;
	assign ch_a.force_evt = force_compare_strobe_a_i;
	assign ch_a.action = output_action_select_a_i;
	assign ch_b.match = match_b;
	assign ch_b.bottom_evt = bottom_evt;
	assign ch_b.pwm_mode = pwm_mode;
	assign ch_b.force_evt = force_compare_strobe_b_i;
	assign ch_b.action = output_action_select_b_i;

	tcwu_output_unit u_out_a (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ch(ch_a)
	);

	tcwu_output_unit u_out_b (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ch(ch_b)
	);

	// ==========================================================
	// Pin override, independent of mode; direction stays with the port
	assign pin_a_o = pin_mux(output_action_select_a_i, ch_a.out_state,
		port_data_a_i);
	assign pin_b_o = pin_mux(output_action_select_b_i, ch_b.out_state,
		port_data_b_i);
	assign pin_a_oe_o = pin_direction_bit_a_i;
	assign pin_b_oe_o = pin_direction_bit_b_i;

	assign counter_value_o = cnt_reg;
	assign compare_value_a_o = sw_view(pwm_mode, buf_a_reg, ocr_a_reg);
	assign compare_value_b_o = sw_view(pwm_mode, buf_b_reg, ocr_b_reg);
	assign overflow_flag_o = tov_reg;
	assign compare_flag_a_o = ocf_a_reg;
	assign compare_flag_b_o = ocf_b_reg;
	assign compare_output_a_o = ch_a.out_state;
	assign compare_output_b_o = ch_b.out_state;
endmodule : tcwu_timer
`default_nettype wire

// [tcwu_timer_monitor.sv]
// Purpose: Port-level checks for the timer compare waveform unit.
// Assumes: One clock; only channel A is watched.
// Notes: Block tracker mirrors match suppression after a counter write.
`default_nettype none
module tcwu_timer_monitor (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic [2:0] waveform_mode_select_i,
	input wire logic [1:0] output_action_select_a_i,
	input wire logic force_compare_strobe_a_i,
	input wire logic counter_write_i,
	input wire logic [7:0] counter_wdata_i,
	input wire logic overflow_flag_clear_i,
	input wire logic port_data_a_i,
	input wire logic pin_direction_bit_a_i,
	input wire logic [7:0] counter_value_o,
	input wire logic [7:0] compare_value_a_o,
	input wire logic overflow_flag_o,
	input wire logic compare_flag_a_o,
	input wire logic compare_output_a_o,
	input wire logic pin_a_o,
	input wire logic pin_a_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========================================
	// Helper logic
	logic blk_reg;
	wire logic go = tick_i && !counter_write_i;
	wire logic [2:0] md = waveform_mode_select_i;
	wire logic hit_a = go && !blk_reg && (counter_value_o == compare_value_a_o);
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) blk_reg <= 1'h0;
		else if (counter_write_i) blk_reg <= 1'h1;
		else if (tick_i) blk_reg <= 1'h0;
	end
	// ==========================================
	// Assertions
	chk_dir_gates_oe: assert property (pin_a_oe_o == pin_direction_bit_a_i)
		else $error("pin enable differs from direction bit");
	chk_port_data_path: assert property ((output_action_select_a_i == 2'h0) |->
		(pin_a_o == port_data_a_i)) else $error("pin not from port data");
	chk_state_override: assert property ((output_action_select_a_i != 2'h0) |->
		(pin_a_o == compare_output_a_o)) else $error("pin not from compare state");
	chk_idle_state_hold: assert property ((output_action_select_a_i == 2'h0) |=>
		$stable(compare_output_a_o)) else $error("state moved with no action");
	chk_normal_wrap: assert property (go && md == 3'h0 && counter_value_o == 8'hFF |=>
		counter_value_o == 8'h00 && overflow_flag_o) else $error("normal wrap wrong");
	chk_match_clear: assert property (hit_a && md == 3'h2 |=>
		counter_value_o == 8'h00 && compare_flag_a_o) else $error("match clear wrong");
	chk_fast_top: assert property (go && md == 3'h3 && counter_value_o == 8'hFF |=>
		counter_value_o == 8'h00 && overflow_flag_o) else $error("fast top wrong");
	chk_hold_no_tick: assert property (!tick_i && !counter_write_i |=>
		$stable(counter_value_o)) else $error("counter moved without tick");
	chk_write_wins: assert property (counter_write_i |=>
		counter_value_o == $past(counter_wdata_i)) else $error("counter write lost");
	chk_flag_sticky: assert property (overflow_flag_o && !overflow_flag_clear_i |=>
		overflow_flag_o) else $error("overflow flag dropped");
	cover property (hit_a && md == 3'h2);
	cover property (go && md == 3'h3 && counter_value_o == 8'hFF);
	cover property (force_compare_strobe_a_i && md == 3'h0 && output_action_select_a_i != 2'h0);
endmodule : tcwu_timer_monitor
bind tcwu_timer tcwu_timer_monitor i_mon (.*);
`default_nettype wire

// [test_timer_compare_waveform_unit.sv]
// Purpose: Self-checking bench for the timer compare waveform unit.
// Assumes: Channel B inputs mirror channel A.
// Notes: Inputs change 1 ns after the rising edge.
`default_nettype none
module test_timer_compare_waveform_unit;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'h0, rst_n_i = 1'h0, tick = 1'h0, frc = 1'h0, cw = 1'h0, aw = 1'h0;
	logic fclr = 1'h0, port_d = 1'h0, dir = 1'h0;
	logic [2:0] mode = 3'h0;
	logic [1:0] act = 2'h0;
	logic [7:0] cwd = 8'h00, awd = 8'h00, cnt, cva;
	logic ovf, cfa, csa, pin, oe, pad;
	logic csb, cfb, pin_b, oe_b;
	logic [7:0] cvb;
	int n_errors = 0, n_compared = 0;
	tcwu_timer i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .tick_i(tick),
		.waveform_mode_select_i(mode), .output_action_select_a_i(act),
		.output_action_select_b_i(act), .force_compare_strobe_a_i(frc),
		.force_compare_strobe_b_i(frc), .counter_write_i(cw), .counter_wdata_i(cwd),
		.compare_value_a_write_i(aw), .compare_value_b_write_i(aw), .compare_wdata_i(awd),
		.overflow_flag_clear_i(fclr), .compare_flag_a_clear_i(fclr),
		.compare_flag_b_clear_i(fclr), .port_data_a_i(port_d), .port_data_b_i(port_d),
		.pin_direction_bit_a_i(dir), .pin_direction_bit_b_i(dir), .counter_value_o(cnt),
		.compare_value_a_o(cva), .compare_value_b_o(cvb), .overflow_flag_o(ovf),
		.compare_flag_a_o(cfa), .compare_flag_b_o(cfb), .compare_output_a_o(csa),
		.compare_output_b_o(csb), .pin_a_o(pin), .pin_a_oe_o(oe), .pin_b_o(pin_b),
		.pin_b_oe_o(oe_b));
	tcwu_pin_model i_pad (.clk_i(clk_i), .drv_i(pin), .oe_i(oe), .level_o(pad));
	// ==========================================
	// Shared tasks
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic cyc();
		@(posedge clk_i);
		#1;
	endtask : cyc
	task automatic ticks(input int n);
		tick = 1'h1;
		repeat (n) cyc();
		tick = 1'h0;
	endtask : ticks
	task automatic wcnt(input logic [7:0] v);
		cwd = v;
		cw = 1'h1;
		cyc();
		cw = 1'h0;
	endtask : wcnt
	task automatic summarize();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize
	// ==========================================
	// Scenarios
	task automatic t_normal();
		mode = 3'h0;
		wcnt(8'hFE);
		ticks(1);
		check("count", cnt, 8'hFF);
		ticks(1);
		check("wrap", cnt, 8'h00);
		check("ovf", ovf, 8'h01);
		cyc();
		check("ovf held", ovf, 8'h01);
		fclr = 1'h1;
		cyc();
		fclr = 1'h0;
		check("ovf cleared", ovf, 8'h00);
	endtask : t_normal
	task automatic t_force_pin();
		act = 2'h1;
		check("oe off", oe, 8'h00);
		frc = 1'h1;
		cyc();
		frc = 1'h0;
		check("forced state", csa, 8'h01);
		check("no flag", cfa, 8'h00);
		check("count kept", cnt, 8'h00);
		dir = 1'h1;
		cyc();
		check("pad state", pad, 8'h01);
		check("pin b", pin_b, 8'h01);
		check("oe b", oe_b, 8'h01);
		act = 2'h0;
		mode = 3'h2;
		#1;
		check("pad port", pad, 8'h00);
		cyc();
		check("state kept", csa, 8'h01);
	endtask : t_force_pin
	task automatic t_ctc();
		act = 2'h1;
		awd = 8'h03;
		aw = 1'h1;
		cyc();
		aw = 1'h0;
		wcnt(8'h00);
		ticks(4);
		check("ctc clear", cnt, 8'h00);
		check("toggle", csa, 8'h00);
		check("cflag", cfa, 8'h01);
		check("cflag b", cfb, 8'h01);
		check("toggle b", csb, 8'h00);
		ticks(4);
		check("period", csa, 8'h01);
		wcnt(8'h03);
		ticks(1);
		check("blocked", cnt, 8'h04);
		check("blocked out", csa, 8'h01);
		ticks(251);
		check("missed top", cnt, 8'hFF);
		ticks(1);
		check("ctc wrap", cnt, 8'h00);
		check("ctc ovf", ovf, 8'h01);
		ticks(4);
		check("late match", cnt, 8'h00);
		check("late toggle", csa, 8'h00);
	endtask : t_ctc
	task automatic t_fast(input logic [1:0] a);
		mode = 3'h0;
		act = a;
		frc = 1'h1;
		cyc();
		frc = 1'h0;
		check("preset", csa, {7'h00, a == 2'h3});
		mode = 3'h3;
		act = a;
		awd = 8'h80;
		aw = 1'h1;
		fclr = 1'h1;
		cyc();
		aw = 1'h0;
		fclr = 1'h0;
		check("buffer", cva, 8'h80);
		check("buffer b", cvb, 8'h80);
		wcnt(8'hFE);
		ticks(2);
		check("top clear", cnt, 8'h00);
		check("top ovf", ovf, 8'h01);
		check("bottom", csa, {7'h00, a == 2'h2});
		wcnt(8'h7F);
		ticks(2);
		check("after match", cnt, 8'h81);
		check("match", csa, {7'h00, a == 2'h3});
	endtask : t_fast
	task automatic t_reset();
		rst_n_i = 1'h0;
		cyc();
		check("rst count", cnt, 8'h00);
		check("rst ovf", ovf, 8'h00);
		check("rst flag", cfa, 8'h00);
		check("rst state", csa, 8'h00);
		check("rst buffer", cva, 8'h00);
		rst_n_i = 1'h1;
		ticks(1);
		check("zero match", csa, 8'h01);
		check("restart", cnt, 8'h01);
	endtask : t_reset
	task automatic t_top7();
		mode = 3'h7;
		act = 2'h1;
		awd = 8'h02;
		aw = 1'h1;
		fclr = 1'h1;
		cyc();
		aw = 1'h0;
		fclr = 1'h0;
		wcnt(8'h00);
		ticks(1);
		check("top7 load", cnt, 8'h00);
		check("top7 ovf", ovf, 8'h01);
		check("top7 hold", csa, 8'h01);
		ticks(3);
		check("top7 clear", cnt, 8'h00);
		check("top7 toggle", csa, 8'h00);
		ticks(3);
		check("top7 period", csa, 8'h01);
	endtask : t_top7
	// ==========================================
	// Run control
	initial forever #5 clk_i = ~clk_i;
	initial begin
		repeat (20) @(posedge clk_i);
		#1;
		rst_n_i = 1'h1;
		cyc();
		t_normal();
		t_force_pin();
		t_ctc();
		t_fast(2'h2);
		t_fast(2'h3);
		t_reset();
		t_top7();
		summarize();
	end
	initial begin
		#100us;
		n_errors++;
		summarize();
	end
endmodule : test_timer_compare_waveform_unit
`default_nettype wire
